// ---- hdl/dcc_consts.vh ----
// constants for the dual comparator control block
`ifndef DCC_CONSTS_VH
`define DCC_CONSTS_VH
`define DCC_SEL_W       3
`define DCC_SEL_OFF     3'h0
`define DCC_SEL_PIN0    3'h0
`define DCC_SEL_PIN1    3'h1
`define DCC_SEL_PIN2    3'h2
`define DCC_SEL_PIN3    3'h3
`define DCC_SEL_DAC     3'h5
`define DCC_SEL_FVR     3'h6
`define DCC_SEL_GND     3'h7
`define DCC_ASEL_NONE   3'h0
`define DCC_ASEL_GND    3'h1
`define DCC_ASEL_FVR    3'h2
`define DCC_ASEL_DAC    3'h3
`define DCC_ASEL_PIN0   3'h4
`define DCC_ASEL_PIN1   3'h5
`define DCC_ASEL_PIN2   3'h6
`define DCC_ASEL_PIN3   3'h7
`define DCC_BIT_RST     1'h0
`define DCC_TRIG_NONE   2'h0
`define DCC_TRIG_CMP1   2'h1
`define DCC_TRIG_CMP2   2'h2
`endif

// ---- hdl/dcc_comparator_control.v ----
// digital control around two analog comparators
`timescale 1ns/100ps
`include "dcc_consts.vh"

module dcc_channel
  (
    // clock and reset
    input  wire                  clk,
    input  wire                  reset_n,
    // controls
    input  wire                  cmpEnable,
    input  wire                  cmpInvert,
    input  wire                  cmpSync,
    input  wire                  riseIrqEnable,
    input  wire                  fallIrqEnable,
    input  wire                  flagClear,
    input  wire [`DCC_SEL_W-1:0] posInputSelect,
    input  wire [`DCC_SEL_W-1:0] negInputSelect,
    // analog result pin and timer clock, both asynchronous
    input  wire                  rawResult,
    input  wire                  timerClkPrescaled,
    // outputs
    output reg  [`DCC_SEL_W-1:0] posMuxSel,
    output reg  [`DCC_SEL_W-1:0] negMuxSel,
    output wire                  pinOut,
    output wire                  resultBit,
    output wire                  irqFlag,
    output wire                  riseEvent
  );

  reg  rawSync1_reg;
  reg  rawSync2_reg;
  reg  tclkSync1_reg;
  reg  tclkSync2_reg;
  reg  tclkPrev_reg;
  reg  syncOut_reg;
  reg  result_reg;
  reg  resultPrev_reg;
  reg  flag_reg;
  wire adjusted;
  wire tclkFall;
  wire rose;
  wire fell;
  reg  flag_next;

  // polarity applied after the enable gate, so toggling invert while off still moves the bit
  assign adjusted = (cmpEnable & rawSync2_reg) ^ cmpInvert;
  assign tclkFall = tclkPrev_reg & ~tclkSync2_reg;

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      rawSync1_reg   <= `DCC_BIT_RST;
      rawSync2_reg   <= `DCC_BIT_RST;
      tclkSync1_reg  <= `DCC_BIT_RST;
      tclkSync2_reg  <= `DCC_BIT_RST;
      tclkPrev_reg   <= `DCC_BIT_RST;
      syncOut_reg    <= `DCC_BIT_RST;
      result_reg     <= `DCC_BIT_RST;
      resultPrev_reg <= `DCC_BIT_RST;
      flag_reg       <= `DCC_BIT_RST;
    end
    else
    begin
      rawSync1_reg   <= rawResult;
      rawSync2_reg   <= rawSync1_reg;
      tclkSync1_reg  <= timerClkPrescaled;
      tclkSync2_reg  <= tclkSync1_reg;
      tclkPrev_reg   <= tclkSync2_reg;
      result_reg     <= adjusted;
      resultPrev_reg <= result_reg;
      flag_reg       <= flag_next;
      if (tclkFall)
      begin
        syncOut_reg <= adjusted;
      end
    end
  end

  // edges between consecutive registered samples
  assign rose = result_reg & ~resultPrev_reg;
  assign fell = ~result_reg & resultPrev_reg;

  always @*
  begin
    flag_next = flag_reg;
    if (flagClear)
    begin
      flag_next = `DCC_BIT_RST;
    end
    // set wins over a clear in the same cycle
    if ((rose & riseIrqEnable) | (fell & fallIrqEnable))
    begin
      flag_next = 1'b1;
    end
  end

  // disabled comparator sees no source on either input
  always @*
  begin
    posMuxSel = cmpEnable ? posInputSelect : `DCC_ASEL_NONE;
    negMuxSel = cmpEnable ? negInputSelect : `DCC_ASEL_NONE;
    case (posInputSelect)
      `DCC_SEL_GND:  posMuxSel = `DCC_ASEL_GND;
      `DCC_SEL_FVR:  posMuxSel = `DCC_ASEL_FVR;
      `DCC_SEL_DAC:  posMuxSel = `DCC_ASEL_DAC;
      `DCC_SEL_PIN1: posMuxSel = `DCC_ASEL_PIN1;
      `DCC_SEL_PIN0: posMuxSel = `DCC_ASEL_PIN0;
      default:       posMuxSel = `DCC_ASEL_NONE;
    endcase
    case (negInputSelect)
      `DCC_SEL_GND:  negMuxSel = `DCC_ASEL_GND;
      `DCC_SEL_FVR:  negMuxSel = `DCC_ASEL_FVR;
      `DCC_SEL_PIN3: negMuxSel = `DCC_ASEL_PIN3;
      `DCC_SEL_PIN2: negMuxSel = `DCC_ASEL_PIN2;
      `DCC_SEL_PIN1: negMuxSel = `DCC_ASEL_PIN1;
      `DCC_SEL_PIN0: negMuxSel = `DCC_ASEL_PIN0;
      default:       negMuxSel = `DCC_ASEL_NONE;
    endcase
    if (!cmpEnable)
    begin
      posMuxSel = `DCC_ASEL_NONE;
      negMuxSel = `DCC_ASEL_NONE;
    end
  end

  // pin path is unregistered unless sync mode picks the timer-edge capture
  assign pinOut    = cmpSync ? syncOut_reg : adjusted;
  assign resultBit = result_reg;
  // the flag level is also the wake request while the core sleeps
  assign irqFlag   = flag_reg;
  assign riseEvent = rose;

endmodule // dcc_channel

module dcc_comparator_control
  (
    // clock and reset
    input  wire                  clk,
    input  wire                  reset_n,
    // comparator 1 controls
    input  wire                  cmp1Enable,
    input  wire                  cmp1Invert,
    input  wire                  cmp1HysteresisOn,
    input  wire                  cmp1Sync,
    input  wire                  cmp1RiseIrqEnable,
    input  wire                  cmp1FallIrqEnable,
    input  wire                  cmp1IrqFlagClear,
    input  wire [`DCC_SEL_W-1:0] cmp1PosInputSelect,
    input  wire [`DCC_SEL_W-1:0] cmp1NegInputSelect,
    // comparator 2 controls
    input  wire                  cmp2Enable,
    input  wire                  cmp2Invert,
    input  wire                  cmp2HysteresisOn,
    input  wire                  cmp2Sync,
    input  wire                  cmp2RiseIrqEnable,
    input  wire                  cmp2FallIrqEnable,
    input  wire                  cmp2IrqFlagClear,
    input  wire [`DCC_SEL_W-1:0] cmp2PosInputSelect,
    input  wire [`DCC_SEL_W-1:0] cmp2NegInputSelect,
    // analog results and prescaled timer clock
    input  wire                  cmp1RawResult,
    input  wire                  cmp2RawResult,
    input  wire                  timerClkPrescaled,
    // system selectors
    input  wire [1:0]            adcTriggerSelect,
    input  wire [1:0]            timerExtResetSelect,
    input  wire                  wavegen1ShutdownEnable,
    input  wire                  wavegen2ShutdownEnable,
    // analog front end controls
    output wire [`DCC_SEL_W-1:0] cmp1PosMux,
    output wire [`DCC_SEL_W-1:0] cmp1NegMux,
    output wire                  cmp1HysteresisReq,
    output wire [`DCC_SEL_W-1:0] cmp2PosMux,
    output wire [`DCC_SEL_W-1:0] cmp2NegMux,
    output wire                  cmp2HysteresisReq,
    // status
    output wire                  cmp1ResultBit,
    output wire                  cmp2ResultBit,
    output wire [1:0]            cmpResultMirror,
    output wire                  cmp1IrqFlag,
    output wire                  cmp2IrqFlag,
    // outputs to pins and peripherals
    output wire                  cmp1PinOut,
    output wire                  cmp2PinOut,
    output wire                  cmp1TimerGate,
    output wire                  cmp2TimerGate,
    output wire                  adcTrigger,
    output wire                  timerExtReset,
    output wire                  wavegenShutdown
  );

  wire rise1;
  wire rise2;

  // two identical, independent instances
  dcc_channel chan1
    (
      .clk               (clk),
      .reset_n           (reset_n),
      .cmpEnable         (cmp1Enable),
      .cmpInvert         (cmp1Invert),
      .cmpSync           (cmp1Sync),
      .riseIrqEnable     (cmp1RiseIrqEnable),
      .fallIrqEnable     (cmp1FallIrqEnable),
      .flagClear         (cmp1IrqFlagClear),
      .posInputSelect    (cmp1PosInputSelect),
      .negInputSelect    (cmp1NegInputSelect),
      .rawResult         (cmp1RawResult),
      .timerClkPrescaled (timerClkPrescaled),
      .posMuxSel         (cmp1PosMux),
      .negMuxSel         (cmp1NegMux),
      .pinOut            (cmp1PinOut),
      .resultBit         (cmp1ResultBit),
      .irqFlag           (cmp1IrqFlag),
      .riseEvent         (rise1)
    );

  dcc_channel chan2
    (
      .clk               (clk),
      .reset_n           (reset_n),
      .cmpEnable         (cmp2Enable),
      .cmpInvert         (cmp2Invert),
      .cmpSync           (cmp2Sync),
      .riseIrqEnable     (cmp2RiseIrqEnable),
      .fallIrqEnable     (cmp2FallIrqEnable),
      .flagClear         (cmp2IrqFlagClear),
      .posInputSelect    (cmp2PosInputSelect),
      .negInputSelect    (cmp2NegInputSelect),
      .rawResult         (cmp2RawResult),
      .timerClkPrescaled (timerClkPrescaled),
      .posMuxSel         (cmp2PosMux),
      .negMuxSel         (cmp2NegMux),
      .pinOut            (cmp2PinOut),
      .resultBit         (cmp2ResultBit),
      .irqFlag           (cmp2IrqFlag),
      .riseEvent         (rise2)
    );

  assign cmp1HysteresisReq = cmp1Enable & cmp1HysteresisOn;
  assign cmp2HysteresisReq = cmp2Enable & cmp2HysteresisOn;
  assign cmpResultMirror   = {cmp2ResultBit, cmp1ResultBit};
  assign cmp1TimerGate     = cmp1PinOut;
  assign cmp2TimerGate     = cmp2PinOut;
  // one-cycle pulses on a rising registered output
  assign adcTrigger    = ((adcTriggerSelect == `DCC_TRIG_CMP1) & rise1) |
                         ((adcTriggerSelect == `DCC_TRIG_CMP2) & rise2);
  assign timerExtReset = ((timerExtResetSelect == `DCC_TRIG_CMP1) & rise1) |
                         ((timerExtResetSelect == `DCC_TRIG_CMP2) & rise2);
  // shutdown taken from the pin outputs, unregistered unless sync mode is on, for an immediate reaction
  assign wavegenShutdown = (wavegen1ShutdownEnable & cmp1PinOut) |
                           (wavegen2ShutdownEnable & cmp2PinOut);

endmodule // dcc_comparator_control

// ---- tb/dcc_cc_assertions.sv ----
// port assertions for the dual comparator control block
`timescale 1ns/100ps
module dcc_cc_assertions
  (
    // clock and reset
    input logic       clk,
    input logic       reset_n,
    // controls and analog result
    input logic       cmp1Enable,
    input logic       cmp1Invert,
    input logic       cmp1HysteresisOn,
    input logic       cmp1RiseIrqEnable,
    input logic       cmp1IrqFlagClear,
    input logic       cmp1RawResult,
    input logic [1:0] adcTriggerSelect,
    input logic [1:0] timerExtResetSelect,
    // outputs
    input logic [2:0] cmp1PosMux,
    input logic       cmp1HysteresisReq,
    input logic       cmp1ResultBit,
    input logic       cmp2ResultBit,
    input logic [1:0] cmpResultMirror,
    input logic       cmp1IrqFlag,
    input logic       adcTrigger,
    input logic       timerExtReset
  );
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  hyst_request_a: assert property (cmp1HysteresisReq == (cmp1Enable && cmp1HysteresisOn))
    else $error("hysteresis request wrong");
  off_mux_a: assert property (!cmp1Enable |-> cmp1PosMux == 3'h0)
    else $error("mux connected while disabled");
  result_follow_a: assert property (
    $rose(cmp1RawResult) ##0 (cmp1RawResult && cmp1Enable && !cmp1Invert)[*4] |-> cmp1ResultBit)
    else $error("result bit missed a rising result");
  mirror_copy_a: assert property (cmpResultMirror == {cmp2ResultBit, cmp1ResultBit})
    else $error("mirror differs from result bits");
  rise_flag_a: assert property ($rose(cmp1ResultBit) && cmp1RiseIrqEnable |=> cmp1IrqFlag)
    else $error("rising edge did not set flag");
  flag_hold_a: assert property (cmp1IrqFlag && !cmp1IrqFlagClear |=> cmp1IrqFlag)
    else $error("flag dropped without clear");
  quiet_flag_a: assert property (!cmp1IrqFlag && $stable(cmp1ResultBit) |=> !cmp1IrqFlag)
    else $error("flag set without an edge");
  adc_pulse_a: assert property (adcTrigger ==
    ((adcTriggerSelect == 2'h1 && $rose(cmp1ResultBit)) || (adcTriggerSelect == 2'h2 && $rose(cmp2ResultBit))))
    else $error("adc trigger pulse wrong");
  timer_reset_a: assert property (timerExtReset ==
    ((timerExtResetSelect == 2'h1 && $rose(cmp1ResultBit)) || (timerExtResetSelect == 2'h2 && $rose(cmp2ResultBit))))
    else $error("timer reset pulse wrong");
  rise_cover: cover property ($rose(cmp1IrqFlag));
  adc_cover: cover property (adcTrigger);
  off_cover: cover property ($fell(cmp1Enable) ##1 $rose(cmp1ResultBit));
endmodule // dcc_cc_assertions

// ---- tb/dcc_afe_model.sv ----
// behavioural analog front end feeding one comparator
`timescale 1ns/100ps
module dcc_afe_model
  #(parameter [4:0] FVR_LEVEL = 5'h14, parameter [4:0] DAC_LEVEL = 5'h0A)
  (
    // mux codes from the block
    input  wire [2:0]  posMux,
    input  wire [2:0]  negMux,
    // four pin levels of four bits
    input  wire [15:0] pinLevel,
    // comparison result
    output wire        rawResult
  );
  // bit 5 marks a connected source
  function [5:0] level(input [2:0] c);
    case (c)
      3'h0: level = 6'h00;
      3'h1: level = 6'h20;
      3'h2: level = {1'b1, FVR_LEVEL};
      3'h3: level = {1'b1, DAC_LEVEL};
      default: level = {2'h2, pinLevel[{c[1:0], 2'h0} +: 4]};
    endcase
  endfunction
  wire [5:0] vp = level(posMux);
  wire [5:0] vn = level(negMux);
  // a floating side reads low, so a disabled comparator cannot look high
  assign rawResult = vp[5] && vn[5] && (vp[4:0] > vn[4:0]);
endmodule // dcc_afe_model

// ---- tb/dcc_comparator_control_test.sv ----
// self-checking bench for the dual comparator control block
`timescale 1ns/100ps
module dcc_comparator_control_test;
  // controls packed as enable, invert, hysteresis, sync, rise, fall, clear
  reg  [6:0]  c1 = 7'h00, c2 = 7'h00;
  reg         clk = 1'b0, reset_n = 1'b0, tclk = 1'b1;
  reg  [2:0]  p1 = 3'h0, n1 = 3'h0, p2 = 3'h0, n2 = 3'h0;
  reg  [1:0]  adcSel = 2'h0, rstSel = 2'h0, wgEn = 2'h0;
  reg  [15:0] lv = 16'h0000;
  wire [2:0]  pm1, nm1, pm2, nm2;
  wire [1:0]  mir;
  wire        raw1, raw2, hr1, hr2, rb1, rb2, f1, f2, po1, po2, tg1, tg2, adc, ter, wgs;
  integer     mismatches = 0, total_checks = 0, i;
  localparam [23:0] POS_MAP = 24'h29802C;
  localparam [23:0] NEG_MAP = 24'h280FAC;
  always #20 clk = ~clk;
  dcc_comparator_control DUT (.clk(clk), .reset_n(reset_n), .cmp1Enable(c1[6]), .cmp1Invert(c1[5]),
    .cmp1HysteresisOn(c1[4]), .cmp1Sync(c1[3]), .cmp1RiseIrqEnable(c1[2]), .cmp1FallIrqEnable(c1[1]),
    .cmp1IrqFlagClear(c1[0]), .cmp1PosInputSelect(p1), .cmp1NegInputSelect(n1), .cmp2Enable(c2[6]),
    .cmp2Invert(c2[5]), .cmp2HysteresisOn(c2[4]), .cmp2Sync(c2[3]), .cmp2RiseIrqEnable(c2[2]),
    .cmp2FallIrqEnable(c2[1]), .cmp2IrqFlagClear(c2[0]), .cmp2PosInputSelect(p2), .cmp2NegInputSelect(n2),
    .cmp1RawResult(raw1), .cmp2RawResult(raw2), .timerClkPrescaled(tclk), .adcTriggerSelect(adcSel),
    .timerExtResetSelect(rstSel), .wavegen1ShutdownEnable(wgEn[0]), .wavegen2ShutdownEnable(wgEn[1]),
    .cmp1PosMux(pm1), .cmp1NegMux(nm1), .cmp1HysteresisReq(hr1), .cmp2PosMux(pm2), .cmp2NegMux(nm2),
    .cmp2HysteresisReq(hr2), .cmp1ResultBit(rb1), .cmp2ResultBit(rb2), .cmpResultMirror(mir),
    .cmp1IrqFlag(f1), .cmp2IrqFlag(f2), .cmp1PinOut(po1), .cmp2PinOut(po2), .cmp1TimerGate(tg1),
    .cmp2TimerGate(tg2), .adcTrigger(adc), .timerExtReset(ter), .wavegenShutdown(wgs));
  dcc_afe_model afe1 (.posMux(pm1), .negMux(nm1), .pinLevel(lv), .rawResult(raw1));
  dcc_afe_model afe2 (.posMux(pm2), .negMux(nm2), .pinLevel(lv), .rawResult(raw2));
  task step(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task check(input string name, input [3:0] seen, input [3:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp)
      begin
        mismatches = mismatches + 1;
        $display("mismatch %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task close_out;
    begin
      if (mismatches == 0 && total_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial
  begin
    step(20);
    reset_n = 1'b1;
    step(1);
    check("flag1", f1, 4'h0);
    check("posmux1", pm1, 4'h0);
    c1 = 7'h40;
    for (i = 0; i < 8; i = i + 1)
    begin
      p1 = i[2:0];
      n1 = i[2:0];
      step(1);
      check("posmux1", pm1, POS_MAP[i*3 +: 3]);
      check("negmux1", nm1, NEG_MAP[i*3 +: 3]);
    end
    lv = 16'h0039;
    p1 = 3'h0;
    n1 = 3'h1;
    c1 = 7'h56;
    adcSel = 2'h1;
    // settle the new selection before trusting the result; enables as software sets them
    step(5);
    check("result1", rb1, 4'h1);
    check("mirror", mir, 4'h1);
    check("hyst1", hr1, 4'h1);
    check("flag1", f1, 4'h1);
    c1 = 7'h57;
    step(1);
    c1 = 7'h76;
    check("flag1", f1, 4'h0);
    step(2);
    check("pinout1", po1, 4'h0);
    check("flag1", f1, 4'h1);
    c1 = 7'h77;
    step(1);
    c1 = 7'h36;
    step(3);
    check("result1", rb1, 4'h1);
    check("flag1", f1, 4'h1);
    check("posmux1", pm1, 4'h0);
    // sync on while the output gates a timer; pin routing is outside this block
    c1 = 7'h4E;
    tclk = 1'b0;
    step(4);
    tclk = 1'b1;
    lv = 16'h0093;
    step(5);
    check("result1", rb1, 4'h0);
    check("pinout1", po1, 4'h1);
    tclk = 1'b0;
    step(4);
    check("pinout1", po1, 4'h0);
    check("gate1", tg1, 4'h0);
    p2 = 3'h6;
    n2 = 3'h1;
    c2 = 7'h56;
    wgEn = 2'h2;
    rstSel = 2'h2;
    step(5);
    check("result2", rb2, 4'h1);
    check("mirror", mir, 4'h2);
    check("shutdown", wgs, 4'h1);
    c2 = 7'h7F;
    step(1);
    c2 = 7'h7E;
    step(2);
    check("result2", rb2, 4'h0);
    check("flag2", f2, 4'h1);
    close_out;
  end
endmodule // dcc_comparator_control_test
bind dcc_comparator_control dcc_cc_assertions chk (.clk(clk), .reset_n(reset_n), .cmp1Enable(cmp1Enable),
  .cmp1Invert(cmp1Invert), .cmp1HysteresisOn(cmp1HysteresisOn), .cmp1RiseIrqEnable(cmp1RiseIrqEnable),
  .cmp1IrqFlagClear(cmp1IrqFlagClear), .cmp1RawResult(cmp1RawResult), .adcTriggerSelect(adcTriggerSelect),
  .timerExtResetSelect(timerExtResetSelect), .timerExtReset(timerExtReset),
  .cmp1PosMux(cmp1PosMux), .cmp1HysteresisReq(cmp1HysteresisReq), .cmp1ResultBit(cmp1ResultBit),
  .cmp2ResultBit(cmp2ResultBit), .cmpResultMirror(cmpResultMirror), .cmp1IrqFlag(cmp1IrqFlag),
  .adcTrigger(adcTrigger));
